// *** common/sdc_cfg.svh ***
// Overview of operation
// - Strap low: address 5A, zero-scale code
// - Strap high: address 58, half-scale code
// - Suspend pin low: hold code, output idles
// - Command bit 7 set enters suspend
// - Suspend pulls regulator shutdown line low
// - Shutdown line stops regulator, DAC keeps driving
// - Sample data on rising bus clock
// - Data line released except acknowledge bits
// - Write Byte: address, command, data
`ifndef SDC_CFG_SVH
`define SDC_CFG_SVH

// Write-direction address bytes (7-bit address plus a zero R/W bit)
`define SDC_ADDR_STRAP_LOW   8'h5A
`define SDC_ADDR_STRAP_HIGH  8'h58

// Power-up DAC codes
`define SDC_CODE_ZERO        6'h00
`define SDC_CODE_HALF        6'h20

// Field positions
`define SDC_CMD_SUSPEND_BIT  7
`define SDC_DATA_CODE_MSB    7
`define SDC_DATA_CODE_LSB    2

// Bit counter marks within one byte frame
`define SDC_BIT_LAST_DATA    4'h7
`define SDC_BIT_ACK          4'h8
`define SDC_BIT_ACK_DONE     4'h9

// Cycles after reset release before the strap level is trusted
`define SDC_STRAP_WAIT       3'h5

// Synchroniser positions of the sampled pins
`define SDC_PIN_SCL          0
`define SDC_PIN_SDA          1
`define SDC_PIN_ADR          2
`define SDC_PIN_SUSP         3
`define SDC_PIN_OFFN         4
`define SDC_PIN_COUNT        5
`define SDC_PIN_IDLE         5'h1B

`endif

// *** common/sdc_pkg.sv ***
package sdc_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_CMD,
        ST_DATA,
        ST_SKIP
    } sdc_phase_type;

    typedef logic [5:0] sdc_code_type;
    typedef logic [7:0] sdc_byte_type;

endpackage

// *** design/sdc_sync.sv ***
`timescale 1ns/1ps

module sdc_sync #(
    parameter int          WIDTH     = 1,
    parameter logic [31:0] RESET_VAL = 32'h0
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] lvl
);

    // Reset value is carried in 32 bits, so wider vectors cannot be served
    generate
        if (WIDTH < 1 || WIDTH > 32) begin : g_width_check
            $error("sdc_sync: WIDTH out of range");
        end
    endgenerate

    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
            logic q1;
            logic q2;
            logic q3;
            logic next_lvl;

            // A change counts only once stages two and three agree
            always_comb begin
                next_lvl = (q2 == q3) ? q3 : lvl[gi];
            end

            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    q1      <= RESET_VAL[gi];
                    q2      <= RESET_VAL[gi];
                    q3      <= RESET_VAL[gi];
                    lvl[gi] <= RESET_VAL[gi];
                end else if (ce) begin
                    q1      <= din[gi];
                    q2      <= q1;
                    q3      <= q2;
                    lvl[gi] <= next_lvl;
                end
            end
        end
    endgenerate

endmodule // sdc_sync

// *** design/sdc_top.sv ***
`timescale 1ns/1ps
`include "sdc_cfg.svh"

module sdc_top (
    input  wire logic                  clk,
    input  wire logic                  rstn,
    input  wire logic                  ce,
    input  wire logic                  smb_clk,
    input  wire logic                  sda_in,
    output logic                       sda_out,
    output logic                       sda_oe,
    input  wire logic                  adr_strap,
    input  wire logic                  suspend_in_n,
    input  wire logic                  regulator_off_n_in,
    output logic                       regulator_off_n_out,
    output logic                       regulator_off_n_oe,
    output logic                       regulator_run,
    output logic                       suspend_active,
    output sdc_pkg::sdc_code_type      dac_current_out
);
    import sdc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset release

    logic rst_meta_n;
    logic rst_sync_n;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Bus clock domain: serial shifter

    sdc_byte_type shift_word;
    sdc_byte_type next_shift_word;

    always_comb begin
        next_shift_word = {shift_word[6:0], sda_in};
    end

    // Bus clock stops between frames, so nothing here waits for an idle edge
    always_ff @(posedge smb_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            shift_word <= 8'h00;
        end else begin
            shift_word <= next_shift_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin sampling in the system clock domain

    logic [`SDC_PIN_COUNT-1:0] pin_raw;
    logic [`SDC_PIN_COUNT-1:0] pin_lvl;

    always_comb begin
        pin_raw                = '0;
        pin_raw[`SDC_PIN_SCL]  = smb_clk;
        pin_raw[`SDC_PIN_SDA]  = sda_in;
        pin_raw[`SDC_PIN_ADR]  = adr_strap;
        pin_raw[`SDC_PIN_SUSP] = suspend_in_n;
        pin_raw[`SDC_PIN_OFFN] = regulator_off_n_in;
    end

    sdc_sync #(
        .WIDTH     (`SDC_PIN_COUNT),
        .RESET_VAL ({27'h0, `SDC_PIN_IDLE})
    ) u_pin_sync (
        .clk   (clk),
        .rst_n (rst_sync_n),
        .ce    (ce),
        .din   (pin_raw),
        .lvl   (pin_lvl)
    );

    logic scl_lvl;
    logic sda_lvl;
    logic adr_lvl;
    logic susp_lvl;
    logic offn_lvl;

    assign scl_lvl  = pin_lvl[`SDC_PIN_SCL];
    assign sda_lvl  = pin_lvl[`SDC_PIN_SDA];
    assign adr_lvl  = pin_lvl[`SDC_PIN_ADR];
    assign susp_lvl = pin_lvl[`SDC_PIN_SUSP];
    assign offn_lvl = pin_lvl[`SDC_PIN_OFFN];

    ////////////////////////////////////////////////////////////////////////////////
    // Protocol state

    sdc_phase_type phase;
    sdc_phase_type next_phase;
    logic          scl_q;
    logic          sda_q;
    logic [3:0]    bit_cnt;
    logic [3:0]    next_bit_cnt;
    sdc_byte_type  byte_q;
    sdc_byte_type  next_byte_q;
    logic          ack_due;
    logic          next_ack_due;
    logic          ack_drive;
    logic          next_ack_drive;
    sdc_code_type  dac_code;
    sdc_code_type  next_dac_code;
    logic          cmd_suspend;
    logic          next_cmd_suspend;
    logic          strap_high;
    logic          next_strap_high;
    logic          strap_done;
    logic          next_strap_done;
    logic [2:0]    strap_cnt;
    logic [2:0]    next_strap_cnt;
    logic          suspend_reg;
    logic          next_suspend_reg;
    logic          run_reg;
    logic          next_run_reg;
    sdc_code_type  out_code;
    sdc_code_type  next_out_code;
    sdc_byte_type  my_addr;

    logic ev_start;
    logic ev_stop;
    logic ev_rise;
    logic ev_fall;

    assign ev_start = ce & scl_lvl & scl_q & sda_q & ~sda_lvl;
    assign ev_stop  = ce & scl_lvl & scl_q & ~sda_q & sda_lvl;
    assign ev_rise  = ce & scl_lvl & ~scl_q;
    assign ev_fall  = ce & ~scl_lvl & scl_q;
    assign my_addr  = strap_high ? `SDC_ADDR_STRAP_HIGH : `SDC_ADDR_STRAP_LOW;

    always_comb begin
        next_phase       = phase;
        next_bit_cnt     = bit_cnt;
        next_byte_q      = byte_q;
        next_ack_due     = ack_due;
        next_ack_drive   = ack_drive;
        next_dac_code    = dac_code;
        next_cmd_suspend = cmd_suspend;
        next_strap_high  = strap_high;
        next_strap_done  = strap_done;
        next_strap_cnt   = strap_cnt;

        // Strap is caught once, after the synchroniser has filled
        if (!strap_done) begin
            if (strap_cnt == `SDC_STRAP_WAIT) begin
                next_strap_done = 1'b1;
                next_strap_high = adr_lvl;
                next_dac_code   = adr_lvl ? `SDC_CODE_HALF : `SDC_CODE_ZERO;
            end else begin
                next_strap_cnt = strap_cnt + 3'h1;
            end
        end else if (ev_start) begin
            // Repeated start also restarts the address phase
            next_phase     = ST_ADDR;
            next_bit_cnt   = 4'h0;
            next_ack_drive = 1'b0;
        end else if (ev_stop) begin
            next_phase     = ST_IDLE;
            next_bit_cnt   = 4'h0;
            next_ack_drive = 1'b0;
        end else if (phase != ST_IDLE) begin
            if (ev_rise) begin
                if (bit_cnt == `SDC_BIT_LAST_DATA) begin
                    // Shifter is stable while the bus clock is high
                    next_byte_q = shift_word;
                    unique case (phase)
                        ST_ADDR: next_ack_due = (shift_word == my_addr);
                        ST_CMD:  next_ack_due = 1'b1;
                        ST_DATA: next_ack_due = 1'b1;
                        ST_SKIP: next_ack_due = 1'b0;
                        ST_IDLE: next_ack_due = 1'b0;
                    endcase
                end
                if (bit_cnt != `SDC_BIT_ACK_DONE) begin
                    next_bit_cnt = bit_cnt + 4'h1;
                end
            end else if (ev_fall) begin
                if (bit_cnt == `SDC_BIT_ACK) begin
                    next_ack_drive = ack_due;
                end else if (bit_cnt == `SDC_BIT_ACK_DONE) begin
                    next_ack_drive = 1'b0;
                    next_bit_cnt   = 4'h0;
                    unique case (phase)
                        ST_ADDR: next_phase = ack_due ? ST_CMD : ST_SKIP;
                        ST_CMD: begin
                            next_cmd_suspend = byte_q[`SDC_CMD_SUSPEND_BIT];
                            next_phase       = ST_DATA;
                        end
                        ST_DATA: begin
                            next_dac_code = byte_q[`SDC_DATA_CODE_MSB:`SDC_DATA_CODE_LSB];
                            next_phase    = ST_SKIP;
                        end
                        ST_SKIP: next_phase = ST_SKIP;
                        ST_IDLE: next_phase = ST_IDLE;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            phase       <= ST_IDLE;
            scl_q       <= 1'b1;
            sda_q       <= 1'b1;
            bit_cnt     <= 4'h0;
            byte_q      <= 8'h00;
            ack_due     <= 1'b0;
            ack_drive   <= 1'b0;
            dac_code    <= `SDC_CODE_ZERO;
            cmd_suspend <= 1'b0;
            strap_high  <= 1'b0;
            strap_done  <= 1'b0;
            strap_cnt   <= 3'h0;
        end else if (ce) begin
            phase       <= next_phase;
            scl_q       <= scl_lvl;
            sda_q       <= sda_lvl;
            bit_cnt     <= next_bit_cnt;
            byte_q      <= next_byte_q;
            ack_due     <= next_ack_due;
            ack_drive   <= next_ack_drive;
            dac_code    <= next_dac_code;
            cmd_suspend <= next_cmd_suspend;
            strap_high  <= next_strap_high;
            strap_done  <= next_strap_done;
            strap_cnt   <= next_strap_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Suspend, shutdown and DAC output

    always_comb begin
        next_suspend_reg = cmd_suspend | ~susp_lvl;
        // Shutdown pin stops only the regulator; the code stays on the output
        next_run_reg     = offn_lvl & ~next_suspend_reg;
        next_out_code    = next_suspend_reg ? `SDC_CODE_ZERO : dac_code;
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            suspend_reg <= 1'b0;
            run_reg     <= 1'b0;
            out_code    <= `SDC_CODE_ZERO;
        end else if (ce) begin
            suspend_reg <= next_suspend_reg;
            run_reg     <= next_run_reg;
            out_code    <= next_out_code;
        end
    end

    assign sda_out             = 1'b0;
    assign sda_oe              = ack_drive;
    assign regulator_off_n_out = 1'b0;
    assign regulator_off_n_oe  = suspend_reg;
    assign regulator_run       = run_reg;
    assign suspend_active      = suspend_reg;
    assign dac_current_out     = out_code;

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions

    property p_shift;
        @(posedge smb_clk) disable iff (!rst_sync_n)
        ##1 shift_word[7:1] == $past(shift_word[6:0]);
    endproperty
    a_shift: assert property (p_shift) else $error("shifter did not advance");

    property p_ack_window;
        @(posedge clk) disable iff (!rst_sync_n)
        sda_oe |-> (bit_cnt == `SDC_BIT_ACK || bit_cnt == `SDC_BIT_ACK_DONE);
    endproperty
    a_ack_window: assert property (p_ack_window) else $error("data driven outside ack");

    property p_strap_low;
        @(posedge clk) disable iff (!rst_sync_n)
        ($rose(strap_done) && !strap_high) |-> (dac_code == 6'h00 && my_addr == 8'h5A);
    endproperty
    a_strap_low: assert property (p_strap_low) else $error("low strap setup wrong");

    property p_strap_high;
        @(posedge clk) disable iff (!rst_sync_n)
        ($rose(strap_done) && strap_high) |-> (dac_code == 6'h20 && my_addr == 8'h58);
    endproperty
    a_strap_high: assert property (p_strap_high) else $error("high strap setup wrong");

    property p_pin_suspend;
        @(posedge clk) disable iff (!rst_sync_n || !ce)
        (!susp_lvl && ce) |=> (suspend_reg && dac_current_out == 6'h00);
    endproperty
    a_pin_suspend: assert property (p_pin_suspend) else $error("pin suspend missed");

    property p_resume;
        @(posedge clk) disable iff (!rst_sync_n || !ce)
        ($rose(susp_lvl) && !cmd_suspend) |=> (dac_current_out == $past(dac_code));
    endproperty
    a_resume: assert property (p_resume) else $error("code not restored");

    property p_cmd_suspend;
        @(posedge clk) disable iff (!rst_sync_n || !ce)
        (ev_fall && bit_cnt == 4'h9 && phase == ST_CMD && byte_q[7]) |=> ##1 suspend_reg;
    endproperty
    a_cmd_suspend: assert property (p_cmd_suspend) else $error("command suspend missed");

    property p_regulator_off_n_pull;
        @(posedge clk) disable iff (!rst_sync_n)
        suspend_active |-> (regulator_off_n_oe && !regulator_off_n_out);
    endproperty
    a_regulator_off_n_pull: assert property (p_regulator_off_n_pull) else $error("shutdown line not pulled");

    property p_reg_off;
        @(posedge clk) disable iff (!rst_sync_n || !ce)
        (!offn_lvl && !next_suspend_reg && ce) |=>
            (!regulator_run && dac_current_out == $past(dac_code));
    endproperty
    a_reg_off: assert property (p_reg_off) else $error("shutdown disturbed DAC");

    property p_ack_cmd_data;
        @(posedge clk) disable iff (!rst_sync_n || !ce)
        (ev_fall && bit_cnt == 4'h8 && (phase == ST_CMD || phase == ST_DATA)) |=> sda_oe;
    endproperty
    a_ack_cmd_data: assert property (p_ack_cmd_data) else $error("byte not acked");

    property p_load;
        @(posedge clk) disable iff (!rst_sync_n || !ce)
        (ev_fall && bit_cnt == 4'h9 && phase == ST_DATA) |=> dac_code == $past(byte_q[7:2]);
    endproperty
    a_load: assert property (p_load) else $error("code not loaded");

    property p_foreign;
        @(posedge clk) disable iff (!rst_sync_n || !ce)
        (ev_fall && bit_cnt == 4'h8 && phase == ST_ADDR && byte_q != my_addr) |=>
            (!sda_oe && $stable(dac_code) && $stable(cmd_suspend));
    endproperty
    a_foreign: assert property (p_foreign) else $error("foreign address acked");

    c_load:    cover property (@(posedge clk) ev_fall && bit_cnt == 4'h9 && phase == ST_DATA);
    c_cmd_sus: cover property (@(posedge clk) $rose(cmd_suspend));
    c_foreign: cover property (@(posedge clk) phase == ST_ADDR ##1 phase == ST_SKIP);
    c_resume:  cover property (@(posedge clk) $rose(susp_lvl) && !cmd_suspend);

endmodule // sdc_top

// *** dv/sdc_host_model.sv ***
`timescale 1ns/1ps

module sdc_host_model (
    input  wire logic tick,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_low
);
    int unsigned low_ticks;

    initial begin
        scl       = 1'b1;
        sda_low   = 1'b0;
        low_ticks = 7;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic wait_ticks(input int n);
        repeat (n) @(posedge tick);
    endtask

    // Clock stands high between frames, as the pull-up leaves it
    task automatic bus_start();
        sda_low = 1'b0;
        scl     = 1'b1;
        wait_ticks(4);
        sda_low = 1'b1;
        wait_ticks(4);
        scl     = 1'b0;
    endtask

    // Data moves well after the clock fall so it never reads as start or stop
    task automatic bus_bit(input logic bit_out, output logic bit_in);
        wait_ticks(3);
        sda_low = ~bit_out;
        wait_ticks(low_ticks - 3);
        scl     = 1'b1;
        wait_ticks(3);
        bit_in  = sda;
        wait_ticks(3);
        scl     = 1'b0;
    endtask

    task automatic bus_byte(input logic [7:0] b, output logic ack, output logic clash);
        logic seen;
        clash = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            bus_bit(b[i], seen);
            if (seen !== b[i]) begin
                clash = 1'b1;
            end
        end
        bus_bit(1'b1, seen);
        ack = (seen === 1'b0);
    endtask

    task automatic bus_stop();
        wait_ticks(3);
        sda_low = 1'b1;
        wait_ticks(low_ticks - 3);
        scl     = 1'b1;
        wait_ticks(4);
        sda_low = 1'b0;
        wait_ticks(8);
    endtask
endmodule // sdc_host_model

// *** dv/test_smbus_dac_suspend_control.sv ***
`timescale 1ns/1ps
`include "sdc_cfg.svh"

module test_smbus_dac_suspend_control;
    import sdc_pkg::*;

    localparam int CYCLE_LIMIT = 50000;

    logic         clk;
    logic         link_tick;
    logic         rstn;
    logic         adr_strap;
    logic         suspend_in_n;
    logic         tb_off_low;
    logic         host_scl;
    logic         host_sda_low;
    logic         sda_line;
    logic         off_line;
    logic         sda_out;
    logic         sda_oe;
    logic         regulator_off_n_out;
    logic         regulator_off_n_oe;
    logic         regulator_run;
    logic         suspend_active;
    sdc_code_type dac_current_out;
    logic [2:0]   acks;
    int           error_cnt;
    int           compares;
    int           cycles = 0;

    // Both lines are open drain with pull-ups
    assign sda_line = ~(host_sda_low | (sda_oe & ~sda_out));
    assign off_line = ~(tb_off_low | (regulator_off_n_oe & ~regulator_off_n_out));

    sdc_top i_sdc_top (
        .clk                 (clk),
        .rstn                (rstn),
        .ce                  (1'b1),
        .smb_clk             (host_scl),
        .sda_in              (sda_line),
        .sda_out             (sda_out),
        .sda_oe              (sda_oe),
        .adr_strap           (adr_strap),
        .suspend_in_n        (suspend_in_n),
        .regulator_off_n_in  (off_line),
        .regulator_off_n_out (regulator_off_n_out),
        .regulator_off_n_oe  (regulator_off_n_oe),
        .regulator_run       (regulator_run),
        .suspend_active      (suspend_active),
        .dac_current_out     (dac_current_out)
    );

    sdc_host_model i_sdc_host_model (
        .tick    (link_tick),
        .sda     (sda_line),
        .scl     (host_scl),
        .sda_low (host_sda_low)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        link_tick = 1'b0;
        #7;
        forever #15 link_tick = ~link_tick;
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == CYCLE_LIMIT) begin
            error_cnt = error_cnt + 1;
            test_done();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        if (error_cnt == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        compares = compares + 1;
        if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic expect_state(input sdc_code_type code, input logic susp, input logic run);
        check({2'b00, dac_current_out}, {2'b00, code}, "dac code");
        check({7'h00, suspend_active}, {7'h00, susp}, "suspend flag");
        check({7'h00, regulator_off_n_oe}, {7'h00, susp}, "shutdown pull-down");
        check({7'h00, regulator_run}, {7'h00, run}, "regulator run");
    endtask

    task automatic do_reset(input logic strap);
        @(negedge clk);
        rstn      = 1'b0;
        adr_strap = strap;
        repeat (16) @(negedge clk);
        rstn = 1'b1;
        repeat (20) @(negedge clk);
    endtask

    task automatic smb_write(input logic [7:0] a, input logic [7:0] c, input logic [7:0] d,
                             input int nbytes, output logic [2:0] ack_seen);
        logic        clash;
        logic        ack_bit;
        logic [23:0] frame;
        frame    = {a, c, d};
        ack_seen = 3'b000;
        i_sdc_host_model.bus_start();
        for (int i = 0; i < nbytes; i++) begin
            i_sdc_host_model.bus_byte(frame[23 - 8 * i -: 8], ack_bit, clash);
            ack_seen[2 - i] = ack_bit;
            check({7'h00, clash}, 8'h00, "data line pulled while shifting");
        end
        i_sdc_host_model.bus_stop();
        repeat (10) @(negedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_strap_low();
        do_reset(1'b0);
        expect_state(`SDC_CODE_ZERO, 1'b0, 1'b1);
        smb_write(`SDC_ADDR_STRAP_LOW, 8'h00, 8'hB6, 3, acks);
        check({5'h00, acks}, 8'h07, "own address acks");
        expect_state(6'h2D, 1'b0, 1'b1);
        smb_write(`SDC_ADDR_STRAP_HIGH, 8'h80, 8'h40, 3, acks);
        check({5'h00, acks}, 8'h00, "foreign address acks");
        expect_state(6'h2D, 1'b0, 1'b1);
    endtask

    // A slow host stretches the clock low phase to test tolerance of long bits
    task automatic t_slow_host();
        i_sdc_host_model.low_ticks = 20;
        smb_write(`SDC_ADDR_STRAP_LOW, 8'h00, 8'h4B, 3, acks);
        check({5'h00, acks}, 8'h07, "slow host acks");
        expect_state(6'h12, 1'b0, 1'b1);
        i_sdc_host_model.low_ticks = 7;
    endtask

    task automatic t_cmd_suspend();
        smb_write(`SDC_ADDR_STRAP_LOW, 8'h80, 8'hFC, 3, acks);
        check({5'h00, acks}, 8'h07, "suspend command acks");
        expect_state(6'h00, 1'b1, 1'b0);
        check({7'h00, off_line}, 8'h00, "shutdown line level");
        smb_write(`SDC_ADDR_STRAP_LOW, 8'h00, 8'h00, 2, acks);
        check({5'h00, acks}, 8'h06, "command only acks");
        expect_state(6'h3F, 1'b0, 1'b1);
    endtask

    task automatic t_pin_suspend();
        @(negedge clk);
        suspend_in_n = 1'b0;
        repeat (8) @(negedge clk);
        expect_state(6'h00, 1'b1, 1'b0);
        check({7'h00, off_line}, 8'h00, "shutdown line level");
        suspend_in_n = 1'b1;
        // Run returns only after the released shutdown line passes its own synchroniser
        repeat (16) @(negedge clk);
        expect_state(6'h3F, 1'b0, 1'b1);
    endtask

    // Regulator held off while a new code is loaded
    task automatic t_shutdown_line();
        @(negedge clk);
        tb_off_low = 1'b1;
        repeat (8) @(negedge clk);
        expect_state(6'h3F, 1'b0, 1'b0);
        smb_write(`SDC_ADDR_STRAP_LOW, 8'h00, 8'h94, 3, acks);
        expect_state(6'h25, 1'b0, 1'b0);
        tb_off_low = 1'b0;
        repeat (8) @(negedge clk);
        expect_state(6'h25, 1'b0, 1'b1);
    endtask

    task automatic t_strap_high();
        do_reset(1'b1);
        expect_state(`SDC_CODE_HALF, 1'b0, 1'b1);
        smb_write(`SDC_ADDR_STRAP_LOW, 8'h80, 8'hFC, 3, acks);
        check({5'h00, acks}, 8'h00, "foreign address acks");
        expect_state(`SDC_CODE_HALF, 1'b0, 1'b1);
        smb_write(`SDC_ADDR_STRAP_HIGH, 8'h00, 8'h0B, 3, acks);
        check({5'h00, acks}, 8'h07, "own address acks");
        expect_state(6'h02, 1'b0, 1'b1);
    endtask

    initial begin
        rstn         = 1'b0;
        adr_strap    = 1'b0;
        suspend_in_n = 1'b1;
        tb_off_low   = 1'b0;
        error_cnt    = 0;
        compares     = 0;
        t_strap_low();
        t_slow_host();
        t_cmd_suspend();
        t_pin_suspend();
        t_shutdown_line();
        t_strap_high();
        test_done();
    end
endmodule // test_smbus_dac_suspend_control
